// ---- common/rx_filter_pkg.sv ----
package rx_filter_pkg;

    // =====================================================================
    // sizes and frame layout
    localparam int NUM_ADDR_FILTERS = 4;
    localparam int NUM_TYPE_MATCH = 4;
    localparam int MAX_FRAME_LEN = 10240;
    localparam int PTR_W = 14;
    localparam logic [PTR_W-1:0] MAX_LEN = 14'h2800;
    localparam logic [PTR_W-1:0] DST_LAST = 14'h0005;
    localparam logic [PTR_W-1:0] SRC_LAST = 14'h000B;
    localparam logic [PTR_W-1:0] TYPE_LAST = 14'h000D;
    localparam int ECC_W = 13;
    localparam int QUEUE_W = 3;

    // =====================================================================
    // configuration carriers
    // byte_mask bit i set excludes addr[8i+7:8i]; addr[47:40] is first on wire
    typedef struct packed {
        logic enable;
        logic use_source;
        logic [5:0] byte_mask;
        logic [47:0] addr;
    } addr_filter_t;

    typedef struct packed {
        logic enable;
        logic [15:0] type_value;
    } type_match_t;

    // field shown on the external filtering port
    typedef enum logic [2:0] {
        FIELD_NONE,
        FIELD_DST,
        FIELD_SRC,
        FIELD_TYPE,
        FIELD_PAYLOAD
    } field_t;

    typedef struct packed {
        logic [7:0] data;
        logic corrected;
        logic uncorrectable;
    } ecc_result_t;

    // =====================================================================
    // single-error-correct double-error-detect code over one byte
    function automatic logic [ECC_W-1:0] ecc_encode(input logic [7:0] d);
        logic [ECC_W-1:0] cw;
        int j;
        cw = '0;
        j = 0;
        for (int p = 1; p <= 12; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p-1] = d[j];
                j = j + 1;
            end
        end
        for (int k = 0; k < 4; k++) begin
            for (int p = 1; p <= 12; p++) begin
                if ((p & (1 << k)) != 0 && (p & (p - 1)) != 0) begin
                    cw[(1 << k) - 1] = cw[(1 << k) - 1] ^ cw[p-1];
                end
            end
        end
        cw[12] = ^cw[11:0];
        return cw;
    endfunction

    function automatic ecc_result_t ecc_decode(input logic [ECC_W-1:0] cw_in);
        logic [ECC_W-1:0] cw;
        logic [3:0] syn;
        logic par;
        ecc_result_t r;
        int j;
        cw = cw_in;
        syn = '0;
        par = ^cw_in;
        r = '0;
        for (int p = 1; p <= 12; p++) begin
            if (cw[p-1]) begin
                syn = syn ^ 4'(p);
            end
        end
        if (syn != 4'h0 && par) begin
            if (syn <= 4'hC) begin
                cw[syn - 4'h1] = ~cw[syn - 4'h1];
                r.corrected = 1'b1;
            end else begin
                r.uncorrectable = 1'b1;
            end
        end else if (syn != 4'h0) begin
            r.uncorrectable = 1'b1;
        end else if (par) begin
            r.corrected = 1'b1;
        end
        j = 0;
        for (int p = 1; p <= 12; p++) begin
            if ((p & (p - 1)) != 0) begin
                r.data[j] = cw[p-1];
                j = j + 1;
            end
        end
        return r;
    endfunction

endpackage

// ---- design/mac_rx_frame_filter.sv ----
// Notes on behaviour
// [RULE1] four specific address filters compare each frame
// [RULE2] each filter picks source or destination address
// [RULE3] masked address bytes are left out
// [RULE4] accepted frames are forwarded to receive DMA
// [RULE5] rejected frames are dropped, never forwarded
// [RULE6] four frame type matchers, each enabled alone
// [RULE7] optional destination address hash filtering
// [RULE8] port shows which header field is present
// [RULE9] strobe pulses once for each parsed field
// [RULE10] external logic latches fields, decides accept/queue
// [RULE11] frames to 10240 bytes buffered with SECDED
// [RULE12] disabled matchers never match; any match accepts (code drops frames with rx_error or over 10240 bytes even on a match)
`timescale 1ns/1ps
`default_nettype none

module mac_rx_frame_filter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_error,
    input wire rx_filter_pkg::addr_filter_t addr_filter [rx_filter_pkg::NUM_ADDR_FILTERS],
    input wire rx_filter_pkg::type_match_t type_match [rx_filter_pkg::NUM_TYPE_MATCH],
    input wire logic hash_enable,
    input wire logic [63:0] hash_table,
    input wire logic copy_all,
    output var rx_filter_pkg::field_t ext_field,
    output logic ext_strobe,
    output logic [47:0] ext_value,
    input wire logic ext_accept,
    input wire logic [rx_filter_pkg::QUEUE_W-1:0] ext_queue,
    output logic dma_valid,
    output logic [7:0] dma_data,
    output logic dma_last,
    output logic [rx_filter_pkg::QUEUE_W-1:0] dma_queue,
    input wire logic dma_ready,
    output logic frame_accepted,
    output logic frame_dropped,
    output logic ecc_corrected,
    output logic ecc_uncorrectable
);

    // =====================================================================
    // state and storage
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RECV,
        ST_EVAL,
        ST_DRAIN
    } state_t;

    state_t state_r, state_nxt;
    logic [rx_filter_pkg::ECC_W-1:0] frame_mem [rx_filter_pkg::MAX_FRAME_LEN];
    logic [rx_filter_pkg::PTR_W-1:0] cnt_r, rd_ptr_r;
    logic [47:0] dst_r, src_r;
    logic [15:0] type_r;
    logic bad_r, in_frame_r;
    rx_filter_pkg::field_t field_r;
    logic strobe_r;
    logic [47:0] value_r;
    logic dma_valid_r, dma_last_r, accepted_r, dropped_r, corr_r, uncorr_r;
    logic [7:0] dma_data_r;
    logic [rx_filter_pkg::QUEUE_W-1:0] queue_r;

    // =====================================================================
    // receive decode
    wire logic start_frame = (state_r == ST_IDLE) && rx_valid && !in_frame_r;
    wire logic take_byte = rx_valid && (start_frame || state_r == ST_RECV);
    wire logic [rx_filter_pkg::PTR_W-1:0] pos = start_frame ? '0 : cnt_r;
    // [RULE11] length limit check
    wire logic fits = pos < rx_filter_pkg::MAX_LEN;
    wire logic end_frame = take_byte && rx_last;

    // =====================================================================
    // matchers
    logic [rx_filter_pkg::NUM_ADDR_FILTERS-1:0] addr_hit;
    logic [rx_filter_pkg::NUM_TYPE_MATCH-1:0] type_hit;

    genvar gi;
    generate
        for (gi = 0; gi < rx_filter_pkg::NUM_ADDR_FILTERS; gi++) begin : g_addr
            // [RULE2] source or destination select
            wire logic [47:0] cand = addr_filter[gi].use_source ? src_r : dst_r;
            wire logic [47:0] diff = cand ^ addr_filter[gi].addr;
            wire logic [5:0] byte_eq;
            for (genvar b = 0; b < 6; b++) begin : g_byte
                // [RULE3] masked byte always equal
                assign byte_eq[b] = addr_filter[gi].byte_mask[b] || (diff[8*b +: 8] == 8'h00);
            end
            // [RULE1] [RULE12] enabled filter compare
            assign addr_hit[gi] = addr_filter[gi].enable && (&byte_eq);
        end
        for (gi = 0; gi < rx_filter_pkg::NUM_TYPE_MATCH; gi++) begin : g_type
            // [RULE6] [RULE12] enabled type compare
            assign type_hit[gi] = type_match[gi].enable && (type_r == type_match[gi].type_value);
        end
    endgenerate

    // [RULE7] six-bit fold of destination address
    wire logic [5:0] hash_idx = dst_r[5:0] ^ dst_r[11:6] ^ dst_r[17:12] ^ dst_r[23:18]
        ^ dst_r[29:24] ^ dst_r[35:30] ^ dst_r[41:36] ^ dst_r[47:42];
    wire logic hash_hit = hash_enable && hash_table[hash_idx];
    // [RULE10] [RULE12] any match or external verdict accepts unless bad_r (rx_error or too long)
    wire logic accept = !bad_r && (copy_all || (|addr_hit) || (|type_hit) || hash_hit
        || ext_accept);

    // =====================================================================
    // drain side: one byte per free output slot
    wire logic out_free = !dma_valid_r || dma_ready;
    wire logic rd_more = rd_ptr_r != cnt_r;
    wire logic load_out = (state_r == ST_DRAIN) && out_free && rd_more;
    wire rx_filter_pkg::ecc_result_t rd_word = rx_filter_pkg::ecc_decode(frame_mem[rd_ptr_r]);
    wire logic drain_done = (state_r == ST_DRAIN) && !rd_more && out_free;

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_frame) begin
                    state_nxt = rx_last ? ST_EVAL : ST_RECV;
                end
            end
            ST_RECV: begin
                if (end_frame) begin
                    state_nxt = ST_EVAL;
                end
            end
            // [RULE4] [RULE5] verdict decides forward or discard
            ST_EVAL: state_nxt = accept ? ST_DRAIN : ST_IDLE;
            ST_DRAIN: begin
                if (drain_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // [RULE11] protected write into frame store
    always_ff @(posedge clk) begin
        if (take_byte && fits) begin
            frame_mem[pos] <= rx_filter_pkg::ecc_encode(rx_data);
        end
    end

    // byte count, stream tracking, error flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            bad_r <= 1'b0;
            in_frame_r <= 1'b0;
        end else begin
            if (rx_valid) begin
                in_frame_r <= !rx_last;
            end
            if (take_byte) begin
                cnt_r <= fits ? pos + 14'h0001 : pos;
                bad_r <= (start_frame ? 1'b0 : bad_r) || rx_error || !fits;
            end
        end
    end

    // header capture, first byte lands in the top byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dst_r <= '0;
            src_r <= '0;
            type_r <= '0;
        end else if (take_byte) begin
            if (pos <= rx_filter_pkg::DST_LAST) begin
                dst_r <= {dst_r[39:0], rx_data};
            end else if (pos <= rx_filter_pkg::SRC_LAST) begin
                src_r <= {src_r[39:0], rx_data};
            end else if (pos <= rx_filter_pkg::TYPE_LAST) begin
                type_r <= {type_r[7:0], rx_data};
            end
        end
    end

    // [RULE8] current field on the external port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            field_r <= rx_filter_pkg::FIELD_NONE;
        end else if (end_frame) begin
            field_r <= rx_filter_pkg::FIELD_NONE;
        end else if (take_byte) begin
            if (pos < rx_filter_pkg::DST_LAST) begin
                field_r <= rx_filter_pkg::FIELD_DST;
            end else if (pos < rx_filter_pkg::SRC_LAST) begin
                field_r <= rx_filter_pkg::FIELD_SRC;
            end else if (pos < rx_filter_pkg::TYPE_LAST) begin
                field_r <= rx_filter_pkg::FIELD_TYPE;
            end else begin
                field_r <= rx_filter_pkg::FIELD_PAYLOAD;
            end
        end
    end

    // [RULE9] strobe with the completed field value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strobe_r <= 1'b0;
            value_r <= '0;
        end else begin
            strobe_r <= take_byte && (pos == rx_filter_pkg::DST_LAST
                || pos == rx_filter_pkg::SRC_LAST || pos == rx_filter_pkg::TYPE_LAST);
            if (take_byte && pos == rx_filter_pkg::DST_LAST) begin
                value_r <= {dst_r[39:0], rx_data};
            end else if (take_byte && pos == rx_filter_pkg::SRC_LAST) begin
                value_r <= {src_r[39:0], rx_data};
            end else if (take_byte && pos == rx_filter_pkg::TYPE_LAST) begin
                value_r <= {32'h0000_0000, type_r[7:0], rx_data};
            end
        end
    end

    // verdict pulses and queue capture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accepted_r <= 1'b0;
            dropped_r <= 1'b0;
            queue_r <= '0;
        end else begin
            accepted_r <= (state_r == ST_EVAL) && accept;
            // frames seen while busy are dropped too
            dropped_r <= ((state_r == ST_EVAL) && !accept)
                || (rx_valid && !in_frame_r && state_r != ST_IDLE && state_r != ST_RECV);
            if (state_r == ST_EVAL) begin
                queue_r <= ext_queue;
            end
        end
    end

    // [RULE4] read out toward the receive DMA
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_ptr_r <= '0;
            dma_valid_r <= 1'b0;
            dma_data_r <= '0;
            dma_last_r <= 1'b0;
            corr_r <= 1'b0;
            uncorr_r <= 1'b0;
        end else begin
            corr_r <= load_out && rd_word.corrected;
            uncorr_r <= load_out && rd_word.uncorrectable;
            if (state_r == ST_EVAL) begin
                rd_ptr_r <= '0;
            end else if (load_out) begin
                rd_ptr_r <= rd_ptr_r + 14'h0001;
            end
            if (load_out) begin
                dma_valid_r <= 1'b1;
                dma_data_r <= rd_word.data;
                dma_last_r <= (rd_ptr_r + 14'h0001) == cnt_r;
            end else if (dma_ready) begin
                dma_valid_r <= 1'b0;
            end
        end
    end

    // output drive
    assign ext_field = field_r;
    assign ext_strobe = strobe_r;
    assign ext_value = value_r;
    assign dma_valid = dma_valid_r;
    assign dma_data = dma_data_r;
    assign dma_last = dma_last_r;
    assign dma_queue = queue_r;
    assign frame_accepted = accepted_r;
    assign frame_dropped = dropped_r;
    assign ecc_corrected = corr_r;
    assign ecc_uncorrectable = uncorr_r;

endmodule // mac_rx_frame_filter

`default_nettype wire

// ---- verif/rx_filter_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module rx_filter_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire rx_filter_pkg::field_t ext_field,
    input wire logic ext_strobe,
    input wire logic [47:0] ext_value,
    input wire logic dma_valid,
    input wire logic [7:0] dma_data,
    input wire logic dma_last,
    input wire logic [rx_filter_pkg::QUEUE_W-1:0] dma_queue,
    input wire logic dma_ready,
    input wire logic frame_accepted,
    input wire logic frame_dropped
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // =========================================
    // filtering port and dma stream checks
    strobe_pulse_a: assert property (ext_strobe |=> !ext_strobe)
        else $error("strobe longer than one cycle");
    value_hold_a: assert property (!ext_strobe |-> $stable(ext_value))
        else $error("field value moved without strobe");
    strobe_field_a: assert property (ext_strobe |-> ext_field != rx_filter_pkg::FIELD_DST)
        else $error("strobe while still in dest field");
    accept_dma_a: assert property (frame_accepted |=> dma_valid)
        else $error("accepted frame not forwarded");
    drop_quiet_a: assert property (
        frame_dropped && !frame_accepted && !dma_valid |=> !dma_valid [*2])
        else $error("dropped frame forwarded");
    beat_hold_a: assert property (
        dma_valid && !dma_ready |=> dma_valid && $stable(dma_data) && $stable(dma_last))
        else $error("dma beat changed while stalled");
    queue_hold_a: assert property (
        dma_valid && !$rose(dma_valid) |-> $stable(dma_queue))
        else $error("queue changed within frame");
    last_beat_a: assert property (dma_valid && dma_ready && dma_last |=> !dma_valid)
        else $error("dma beat after last");

    cover property (frame_accepted);
    cover property (frame_dropped);
    cover property (dma_valid && !dma_ready);
endmodule // rx_filter_checker

bind mac_rx_frame_filter rx_filter_checker chk (.clk, .resetn, .ext_field, .ext_strobe,
    .ext_value, .dma_valid, .dma_data, .dma_last, .dma_queue, .dma_ready,
    .frame_accepted, .frame_dropped);

`default_nettype wire

// ---- verif/fabric_partner.sv ----
`timescale 1ns/1ps
`default_nettype none

module fabric_partner #(
    parameter logic [15:0] WANT_TYPE = 16'h88B5
) (
    input wire logic clk,
    input wire logic resetn,
    input wire rx_filter_pkg::field_t ext_field,
    input wire logic ext_strobe,
    input wire logic [47:0] ext_value,
    output logic ext_accept,
    output logic [rx_filter_pkg::QUEUE_W-1:0] ext_queue,
    output logic dma_ready
);
    logic [15:0] type_r;
    logic [1:0] stall_r;

    // latch type field on its strobe, stall the sink one cycle in four
    // latch strobed field
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            type_r <= 16'h0000;
            stall_r <= 2'h0;
        end else begin
            stall_r <= stall_r + 2'h1;
            if (ext_strobe && ext_field == rx_filter_pkg::FIELD_PAYLOAD) begin
                type_r <= ext_value[15:0];
            end
        end
    end

    assign ext_accept = (type_r == WANT_TYPE);
    assign ext_queue = type_r[2:0];
    assign dma_ready = (stall_r != 2'h3);
endmodule // fabric_partner

`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam logic [47:0] DST = 48'h021122334455;
    localparam logic [47:0] SRC = 48'h02667788A9BA;
    logic clk, resetn, rx_valid, rx_last, rx_error, hash_enable, copy_all;
    logic [7:0] rx_data, dma_data;
    rx_filter_pkg::addr_filter_t af [rx_filter_pkg::NUM_ADDR_FILTERS];
    rx_filter_pkg::type_match_t tm [rx_filter_pkg::NUM_TYPE_MATCH];
    rx_filter_pkg::field_t ext_field;
    logic [63:0] hash_table;
    logic [47:0] ext_value;
    logic [2:0] ext_queue, dma_queue;
    logic ext_strobe, ext_accept, dma_valid, dma_last, dma_ready;
    logic frame_accepted, frame_dropped, ecc_c, ecc_u, acc_seen, drop_seen;
    logic [127:0] fr;
    int failures, comparisons, nrx, nstb, flen;

    mac_rx_frame_filter uut (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_error(rx_error), .addr_filter(af),
        .type_match(tm), .hash_enable(hash_enable), .hash_table(hash_table),
        .copy_all(copy_all), .ext_field(ext_field), .ext_strobe(ext_strobe),
        .ext_value(ext_value), .ext_accept(ext_accept), .ext_queue(ext_queue),
        .dma_valid(dma_valid), .dma_data(dma_data), .dma_last(dma_last),
        .dma_queue(dma_queue), .dma_ready(dma_ready), .frame_accepted(frame_accepted),
        .frame_dropped(frame_dropped), .ecc_corrected(ecc_c), .ecc_uncorrectable(ecc_u));

    fabric_partner partner (.clk(clk), .resetn(resetn), .ext_field(ext_field),
        .ext_strobe(ext_strobe), .ext_value(ext_value), .ext_accept(ext_accept),
        .ext_queue(ext_queue), .dma_ready(dma_ready));

    // =========================================
    // helpers
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [5:0] hash_idx(input logic [47:0] a);
        hash_idx = 6'h00;
        for (int i = 0; i < 8; i++) hash_idx = hash_idx ^ a[6*i +: 6];
    endfunction

    // send one frame, then judge verdict, forwarded bytes and strobes
    task automatic run(input string name, input logic [15:0] ty, input int err, input logic acc);
        int n;
        fr = {DST, SRC, ty, 16'hC33C};
        nrx = 0;
        nstb = 0;
        acc_seen = 1'b0;
        drop_seen = 1'b0;
        // frames longer than the header image are padded with zero bytes
        for (int i = 0; i < flen; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= (i < 16) ? fr[127-8*i -: 8] : 8'h00;
            rx_last <= (i == flen - 1);
            rx_error <= (i == err);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_error <= 1'b0;
        n = 0;
        while (n < 60 && !(drop_seen || (acc_seen && nrx == 16 && !dma_valid))) begin
            @(posedge clk);
            n++;
        end
        check("finished", 48'(n < 60), 48'h1);
        repeat (4) @(posedge clk);
        check("verdict", {46'h0, acc_seen, drop_seen}, {46'h0, acc, !acc});
        check("dma_bytes", 48'(nrx), acc ? 48'h10 : 48'h0);
        check("strobes", 48'(nstb), 48'h3);
        $display("test %s done", name);
    endtask

    // =========================================
    // monitor of verdict pulses, strobes and dma beats
    always @(posedge clk) begin
        if (frame_accepted === 1'b1) acc_seen <= 1'b1;
        if (frame_dropped === 1'b1) drop_seen <= 1'b1;
        if (ext_strobe === 1'b1) begin
            check("ext_value", ext_value,
                nstb == 0 ? DST : (nstb == 1 ? SRC : {32'h0, fr[31:16]}));
            check("ext_field", {45'h0, ext_field},
                {45'h0, nstb == 0 ? rx_filter_pkg::FIELD_SRC :
                (nstb == 1 ? rx_filter_pkg::FIELD_TYPE : rx_filter_pkg::FIELD_PAYLOAD)});
            nstb <= nstb + 1;
        end
        if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
            check("dma_data", {40'h0, dma_data}, {40'h0, fr[127-8*nrx -: 8]});
            check("dma_end", {44'h0, dma_last, dma_queue}, {44'h0, nrx == 15, fr[18:16]});
            check("ecc", {46'h0, ecc_c, ecc_u}, 48'h0);
            nrx <= nrx + 1;
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end

    // =========================================
    // tests
    initial begin
        {resetn, rx_valid, rx_last, rx_error, hash_enable, copy_all} = 6'h00;
        rx_data = 8'h00;
        hash_table = 64'h0;
        failures = 0;
        comparisons = 0;
        flen = 16;
        for (int i = 0; i < 4; i++) begin
            af[i] = '0;
            tm[i] = '0;
        end
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        run("no_match", 16'h0800, -1, 1'b0);
        for (int f = 0; f < 4; f++) begin
            @(posedge clk) af[f] <= '{1'b1, 1'b0, 6'h00, DST};
            run("dst_filter", 16'h0800, -1, 1'b1);
            @(posedge clk) af[f].enable <= 1'b0;
            run("filter_off", 16'h0800, -1, 1'b0);
        end
        @(posedge clk) af[2] <= '{1'b1, 1'b1, 6'h00, DST};
        run("src_select", 16'h0800, -1, 1'b0);
        @(posedge clk) af[2].addr <= SRC ^ 48'h0000000000FF;
        run("src_unmasked", 16'h0800, -1, 1'b0);
        @(posedge clk) af[2].byte_mask <= 6'h01;
        run("src_masked", 16'h0800, -1, 1'b1);
        @(posedge clk) af[2].enable <= 1'b0;
        for (int t = 0; t < 4; t++) begin
            @(posedge clk) tm[t] <= '{1'b1, 16'h0800};
            run("type_match", 16'h0800, -1, 1'b1);
            @(posedge clk) tm[t].enable <= 1'b0;
        end
        @(posedge clk) hash_table <= ~(64'h1 << hash_idx(DST));
        hash_enable <= 1'b1;
        run("hash_miss", 16'h0800, -1, 1'b0);
        @(posedge clk) hash_table <= 64'h1 << hash_idx(DST);
        run("hash_hit", 16'h0800, -1, 1'b1);
        @(posedge clk) hash_enable <= 1'b0;
        run("external", 16'h88B5, -1, 1'b1);
        @(posedge clk) copy_all <= 1'b1;
        run("copy_all", 16'h0800, -1, 1'b1);
        run("rx_error", 16'h0800, 3, 1'b0);
        // one byte past the length limit drops the frame even with copy_all
        flen = 10241;
        run("too_long", 16'h0800, -1, 1'b0);
        test_done();
    end
endmodule // tb_top

`default_nettype wire
